// file: scu_map.svh
`ifndef SCU_MAP_SVH
`define SCU_MAP_SVH
// ---------------------------------------------------------------------------
// Mode select values
// ---------------------------------------------------------------------------
`define SCU_MODE_UART    2'h1
// ---------------------------------------------------------------------------
// FIFO geometry and thresholds
// ---------------------------------------------------------------------------
`define SCU_FIFO_DEPTH   3'h4
`define SCU_RTS_ROOM     3'h2
`define SCU_PER_MIN      16'h0008
// ---------------------------------------------------------------------------
// Stored receive entry layout: {frm, par, data[7:0]}
// ---------------------------------------------------------------------------
`define SCU_ENT_PAR      8
`define SCU_ENT_FRM      9
`define SCU_OFS_NONE     8'hff
// Flag levels seen at rest: all-sent and space high, the rest low
`define SCU_EV_IDLE      7'h60
`endif

// file: scu_pkg.sv
package scu_pkg;
    typedef enum logic [3:0] {
        SCU_TX_IDLE  = 4'h1,
        SCU_TX_START = 4'h2,
        SCU_TX_BITS  = 4'h4,
        SCU_TX_STOP  = 4'h8
    } scu_tx_state_t;
    typedef enum logic [3:0] {
        SCU_RX_IDLE  = 4'h1,
        SCU_RX_START = 4'h2,
        SCU_RX_BITS  = 4'h4,
        SCU_RX_STOP  = 4'h8
    } scu_rx_state_t;
endpackage

// file: scu_uart.sv
`timescale 1ns/1ps
`include "scu_map.svh"
// Contract
// - UART runs only when mode select is one
// - Exactly one serial mode active at once
// - Bit rate is clk over 2*(N+F/2)
// - Seven/eight data, parity options, one/two stops
// - Auto RTS asserted while two bytes fit
// - Manual RTS follows software level bit
// - Four-entry transmit and receive FIFOs
// - Write into empty TX FIFO clears all-sent
// - TX space flag clears when FIFO full
// - Character loaded into the shifter sets TX space again
// - Empty FIFO and last shifted sets all-sent
// - Each RX byte stored with its errors
// - RX valid set while unread bytes remain
// - DMA records first error offset per buffer
// - Byte arriving into full FIFO dropped, overrun
// - Overrun during DMA recorded as error offset
// - Overrun irq at once, DMA after drain
// - DMA error cleared by reset or reload
// - Events on rising all-sent, space, valid flags
// - Events on DMA done, parity, frame, overrun
module scu_uart
    import scu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [1:0]  serial_mode_select_i,
    input  wire logic [15:0] baud_period_integer_i,
    input  wire logic        baud_period_half_step_i,
    input  wire logic        eight_data_bits_i,
    input  wire logic        two_stop_bits_i,
    input  wire logic        parity_enable_i,
    input  wire logic        odd_parity_select_i,
    input  wire logic        flow_control_enable_i,
    input  wire logic        auto_rts_enable_i,
    input  wire logic        rts_manual_level_i,
    input  wire logic        tx_wr_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        rx_rd_i,
    input  wire logic        rx_dma_i,
    input  wire logic        rx_dma_buf_b_i,
    input  wire logic [7:0]  rx_dma_offset_i,
    input  wire logic [1:0]  dma_channel_reset_i,
    input  wire logic [1:0]  rx_dma_reload_i,
    input  wire logic [1:0]  tx_dma_buffer_active_i,
    input  wire logic [1:0]  rx_dma_buffer_active_i,
    input  wire logic        rxd_i,
    input  wire logic        clear_to_send_n_i,
    output logic             txd_o,
    output logic             request_to_send_n_o,
    output logic [7:0]       serial_data_port_o,
    output logic             tx_all_sent_o,
    output logic             tx_fifo_has_space_o,
    output logic             rx_fifo_has_data_o,
    output logic             rx_parity_error_o,
    output logic             rx_framing_error_o,
    output logic             rx_overrun_flag_o,
    output logic [7:0]       rx_dma_error_offset_a_o,
    output logic [7:0]       rx_dma_error_offset_b_o,
    output logic             uart_event_o,
    output logic             rx_overrun_irq_o
);
    // -----------------------------------------------------------------------
    // Mode gate and baud generator
    // -----------------------------------------------------------------------
    logic        en;
    logic [16:0] bcnt_r;
    logic        half_r;
    logic        tick;
    logic [16:0] bper;
    // Only the UART decode enables this engine; other modes hold it idle
    assign en   = (serial_mode_select_i == `SCU_MODE_UART);
    // Half-bit tick every N+F/2 cycles, fraction alternates an extra cycle
    assign bper = {1'b0, baud_period_integer_i} + {16'h0000, half_r & baud_period_half_step_i};
    assign tick = en && (bcnt_r + 17'h00001 >= bper);

    always_ff @(posedge clk_i) begin
        if (srst_i || !en) begin
            bcnt_r <= 17'h00000;
            half_r <= 1'b0;
        end else if (tick) begin
            bcnt_r <= 17'h00000;
            half_r <= ~half_r;
        end else begin
            bcnt_r <= bcnt_r + 17'h00001;
        end
    end

    // -----------------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------------
    logic rxd_m_r, rxd_s_r, cts_m_r, cts_s_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            cts_m_r <= 1'b1;
            cts_s_r <= 1'b1;
        end else begin
            rxd_m_r <= rxd_i;
            rxd_s_r <= rxd_m_r;
            cts_m_r <= clear_to_send_n_i;
            cts_s_r <= cts_m_r;
        end
    end

    // -----------------------------------------------------------------------
    // Transmit FIFO
    // -----------------------------------------------------------------------
    logic [7:0] txq_r [4];
    logic [1:0] txw_r, txr_r;
    logic [2:0] txc_r;
    logic       tx_pop;
    logic       tx_push;
    assign tx_push = tx_wr_i && (txc_r != `SCU_FIFO_DEPTH);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            txw_r <= 2'h0;
            txr_r <= 2'h0;
            txc_r <= 3'h0;
        end else begin
            if (tx_push) begin
                txq_r[txw_r] <= tx_data_i;
                txw_r        <= txw_r + 2'h1;
            end
            if (tx_pop) begin
                txr_r <= txr_r + 2'h1;
            end
            txc_r <= txc_r + {2'h0, tx_push} - {2'h0, tx_pop};
        end
    end

    // -----------------------------------------------------------------------
    // Transmit serializer, counts half-bit ticks
    // -----------------------------------------------------------------------
    scu_tx_state_t tst_r;
    logic [8:0]    tsh_r;
    logic [3:0]    tbit_r;
    logic          thalf_r;
    logic [3:0]    tlen;
    logic          cts_ok;
    // Parity bit rides as the last shifted bit
    assign tlen   = (eight_data_bits_i ? 4'h8 : 4'h7) + {3'h0, parity_enable_i};
    assign cts_ok = !flow_control_enable_i || !cts_s_r;
    assign tx_pop = (tst_r == SCU_TX_IDLE) && en && (txc_r != 3'h0) && cts_ok && tick;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tst_r   <= SCU_TX_IDLE;
            tsh_r   <= 9'h1ff;
            tbit_r  <= 4'h0;
            thalf_r <= 1'b0;
            txd_o   <= 1'b1;
        end else if (tst_r == SCU_TX_IDLE) begin
            txd_o <= 1'b1;
            if (tx_pop) begin
                tsh_r   <= {1'b0, txq_r[txr_r]};
                // Without parity the last data bit stays as loaded
                if (parity_enable_i)
                    tsh_r[tlen - 4'h1] <= (eight_data_bits_i ? ^txq_r[txr_r]
                                          : ^txq_r[txr_r][6:0]) ^ odd_parity_select_i;
                txd_o   <= 1'b0;
                thalf_r <= 1'b0;
                tst_r   <= SCU_TX_START;
            end
        end else if (tick) begin
            thalf_r <= ~thalf_r;
            if (thalf_r) begin
                case (tst_r)
                    SCU_TX_START: begin
                        txd_o  <= tsh_r[0];
                        tsh_r  <= {1'b1, tsh_r[8:1]};
                        tbit_r <= 4'h1;
                        tst_r  <= SCU_TX_BITS;
                    end
                    SCU_TX_BITS: begin
                        if (tbit_r == tlen) begin
                            txd_o  <= 1'b1;
                            tbit_r <= 4'h0;
                            tst_r  <= SCU_TX_STOP;
                        end else begin
                            txd_o  <= tsh_r[0];
                            tsh_r  <= {1'b1, tsh_r[8:1]};
                            tbit_r <= tbit_r + 4'h1;
                        end
                    end
                    SCU_TX_STOP: begin
                        if (tbit_r == {3'h0, two_stop_bits_i}) begin
                            tst_r <= SCU_TX_IDLE;
                        end else begin
                            tbit_r <= tbit_r + 4'h1;
                        end
                    end
                    default: tst_r <= SCU_TX_IDLE;
                endcase
            end
        end
    end

    // Status: all-sent needs empty FIFO and idle shifter
    assign tx_all_sent_o       = (txc_r == 3'h0) && (tst_r == SCU_TX_IDLE);
    assign tx_fifo_has_space_o = (txc_r != `SCU_FIFO_DEPTH);

    // -----------------------------------------------------------------------
    // Receiver, samples mid-bit on half ticks
    // -----------------------------------------------------------------------
    scu_rx_state_t rst_r;
    logic [8:0]    rsh_r;
    logic [3:0]    rbit_r;
    logic          rhalf_r;
    logic          rx_done;
    logic          rpar_err;
    logic          rfrm_err;
    logic [7:0]    rdata;
    assign rdata    = eight_data_bits_i ? rsh_r[7:0] : {1'b0, rsh_r[6:0]};
    assign rpar_err = parity_enable_i &&
        ((^rdata) ^ rsh_r[tlen - 4'h1] ^ odd_parity_select_i);
    assign rfrm_err = !rxd_s_r;
    assign rx_done  = (rst_r == SCU_RX_STOP) && tick && !rhalf_r;

    always_ff @(posedge clk_i) begin
        if (srst_i || !en) begin
            rst_r   <= SCU_RX_IDLE;
            rsh_r   <= 9'h000;
            rbit_r  <= 4'h0;
            rhalf_r <= 1'b0;
        end else begin
            case (rst_r)
                SCU_RX_IDLE: begin
                    if (!rxd_s_r && tick) begin
                        rhalf_r <= 1'b1;
                        rst_r   <= SCU_RX_START;
                    end
                end
                SCU_RX_START: begin
                    if (tick) begin
                        // False start on a glitch returns to idle
                        if (rxd_s_r) rst_r <= SCU_RX_IDLE;
                        else begin
                            rhalf_r <= 1'b0;
                            rbit_r  <= 4'h0;
                            rst_r   <= SCU_RX_BITS;
                        end
                    end
                end
                SCU_RX_BITS: begin
                    if (tick) begin
                        rhalf_r <= ~rhalf_r;
                        if (rhalf_r) begin
                            rsh_r[rbit_r] <= rxd_s_r;
                            rbit_r        <= rbit_r + 4'h1;
                            if (rbit_r + 4'h1 == tlen) rst_r <= SCU_RX_STOP;
                        end
                    end
                end
                SCU_RX_STOP: begin
                    if (tick) rhalf_r <= ~rhalf_r;
                    if (rx_done) rst_r <= SCU_RX_IDLE;
                end
                default: rst_r <= SCU_RX_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Receive FIFO with per-byte error bits
    // -----------------------------------------------------------------------
    logic [9:0] rxq_r [4];
    logic [1:0] rxw_r, rxr_r;
    logic [2:0] rxc_r;
    logic       rx_push, rx_pop, rx_drop;
    assign rx_push = rx_done && (rxc_r != `SCU_FIFO_DEPTH);
    assign rx_drop = rx_done && (rxc_r == `SCU_FIFO_DEPTH);
    assign rx_pop  = (rx_rd_i || rx_dma_i) && (rxc_r != 3'h0);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rxw_r <= 2'h0;
            rxr_r <= 2'h0;
            rxc_r <= 3'h0;
        end else begin
            if (rx_push) begin
                rxq_r[rxw_r] <= {rfrm_err, rpar_err, rdata};
                rxw_r        <= rxw_r + 2'h1;
            end
            if (rx_pop) rxr_r <= rxr_r + 2'h1;
            rxc_r <= rxc_r + {2'h0, rx_push} - {2'h0, rx_pop};
        end
    end
    assign serial_data_port_o = rxq_r[rxr_r][7:0];
    assign rx_parity_error_o  = (rxc_r != 3'h0) && rxq_r[rxr_r][`SCU_ENT_PAR];
    assign rx_framing_error_o = (rxc_r != 3'h0) && rxq_r[rxr_r][`SCU_ENT_FRM];
    assign rx_fifo_has_data_o = (rxc_r != 3'h0);

    // Overrun flag sticky until software reads a byte; set wins
    logic ovf_pend_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) rx_overrun_flag_o <= 1'b0;
        else if (rx_drop) rx_overrun_flag_o <= 1'b1;
        else if (rx_rd_i) rx_overrun_flag_o <= 1'b0;
    end
    assign rx_overrun_irq_o = rx_drop;

    // RTS: auto keeps two free slots, manual follows the level bit
    always_ff @(posedge clk_i) begin
        if (srst_i) request_to_send_n_o <= 1'b1;
        else if (!flow_control_enable_i) request_to_send_n_o <= 1'b1;
        else if (auto_rts_enable_i)
            request_to_send_n_o <= !(`SCU_FIFO_DEPTH - rxc_r >= `SCU_RTS_ROOM);
        else request_to_send_n_o <= !rts_manual_level_i;
    end

    // -----------------------------------------------------------------------
    // DMA error offsets, one per buffer; overrun shown after drain
    // -----------------------------------------------------------------------
    logic dma_err;
    assign dma_err = rx_dma_i && rx_pop &&
        (rxq_r[rxr_r][`SCU_ENT_PAR] || rxq_r[rxr_r][`SCU_ENT_FRM]);
    always_ff @(posedge clk_i) begin
        if (srst_i) ovf_pend_r <= 1'b0;
        else if (rx_drop && |rx_dma_buffer_active_i) ovf_pend_r <= 1'b1;
        else if (ovf_pend_r && rxc_r == 3'h0) ovf_pend_r <= 1'b0;
    end
    genvar g;
    logic [1:0] err_now;
    for (g = 0; g < 2; g++) begin : g_buf
        logic [7:0] ofs_r;
        logic       sel;
        assign sel        = (g == 0) ? !rx_dma_buf_b_i : rx_dma_buf_b_i;
        assign err_now[g] = sel && (dma_err || (ovf_pend_r && rxc_r == 3'h0));
        always_ff @(posedge clk_i) begin
            if (srst_i) ofs_r <= `SCU_OFS_NONE;
            else if (err_now[g] && ofs_r == `SCU_OFS_NONE)
                ofs_r <= rx_dma_offset_i;
            else if (dma_channel_reset_i[g] || rx_dma_reload_i[g])
                ofs_r <= `SCU_OFS_NONE;
        end
    end
    assign rx_dma_error_offset_a_o = g_buf[0].ofs_r;
    assign rx_dma_error_offset_b_o = g_buf[1].ofs_r;

    // -----------------------------------------------------------------------
    // Event pulse on flag edges; CPU masking sits outside
    // -----------------------------------------------------------------------
    logic [6:0] evp_r;
    logic [6:0] evc;
    assign evc = {tx_all_sent_o, tx_fifo_has_space_o, rx_fifo_has_data_o,
                  tx_dma_buffer_active_i, rx_dma_buffer_active_i};
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            evp_r        <= `SCU_EV_IDLE; // No false edge right after reset
            uart_event_o <= 1'b0;
        end else begin
            evp_r        <= evc;
            uart_event_o <= |(evc[6:4] & ~evp_r[6:4])
                         || |(~evc[3:0] & evp_r[3:0])
                         || (rx_push && (rpar_err || rfrm_err)) || rx_drop;
        end
    end
endmodule

// file: scu_uart_sva.sv
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module scu_uart_sva (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic [1:0] serial_mode_select_i,
    input wire logic       flow_control_enable_i,
    input wire logic       auto_rts_enable_i,
    input wire logic       rts_manual_level_i,
    input wire logic       tx_wr_i,
    input wire logic       rx_rd_i,
    input wire logic       rx_dma_i,
    input wire logic       txd_o,
    input wire logic       request_to_send_n_o,
    input wire logic       tx_all_sent_o,
    input wire logic       tx_fifo_has_space_o,
    input wire logic       rx_fifo_has_data_o,
    input wire logic       rx_overrun_flag_o,
    input wire logic       uart_event_o,
    input wire logic       rx_overrun_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic on;
    // Other modes are excluded, the receiver is held there
    assign on = serial_mode_select_i == 2'h1;

    a_wr_clears_idle: assert property (
        tx_all_sent_o && tx_wr_i && on |=> !tx_all_sent_o) else $error("idle after write");
    a_idle_has_space: assert property (
        tx_all_sent_o |-> tx_fifo_has_space_o) else $error("idle but no space");
    a_idle_line_high: assert property (
        tx_all_sent_o |-> txd_o) else $error("idle but line low");
    a_valid_holds: assert property (
        rx_fifo_has_data_o && !rx_rd_i && !rx_dma_i && on |=> rx_fifo_has_data_o)
        else $error("valid lost without read");
    a_ovf_sets_flag: assert property (
        rx_overrun_irq_o |=> rx_overrun_flag_o) else $error("overrun flag not set");
    a_auto_rts_empty: assert property (
        flow_control_enable_i && auto_rts_enable_i && on && !rx_fifo_has_data_o
        |=> !request_to_send_n_o) else $error("auto rts off while empty");
    a_manual_rts: assert property (
        flow_control_enable_i && !auto_rts_enable_i && on
        |=> request_to_send_n_o == !$past(rts_manual_level_i)) else $error("manual rts");
    a_space_event: assert property (
        $rose(tx_fifo_has_space_o) && !$past(srst_i) |-> ##[0:2] uart_event_o)
        else $error("no event on space");

    c_ovf: cover property (rx_overrun_irq_o);
    c_idle: cover property ($rose(tx_all_sent_o));
    c_rts: cover property ($fell(request_to_send_n_o));
endmodule

// file: scu_term.sv
`timescale 1ns/1ps
// ----------
// Remote terminal model
// ----------
module scu_term #(
    parameter int BIT = 16
) (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o,
    output logic      cts_n_o
);
    logic [8:0] got_q[$];
    logic [8:0] sh;
    // Line idles high; always clear to send
    initial begin
        rxd_o = 1'b1;
        cts_n_o = 1'b0;
    end
    // Start, 8 data LSB first, parity, stop; faults only on request
    task automatic send(input logic [7:0] b, input logic odd, input logic bp,
                        input logic bs);
        logic [10:0] f;
        f = {~bs, ^b ^ odd ^ bp, b, 1'b0};
        @(posedge clk_i);
        #1;
        for (int i = 0; i < 11; i++) begin
            rxd_o = f[i];
            repeat (BIT) @(posedge clk_i);
            #1;
        end
        rxd_o = 1'b1;
    endtask
    // Mid-bit sampling; a drifting bit rate shows as wrong bits
    always begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk_i);
            sh[i] = txd_i;
        end
        got_q.push_back(sh);
    end
endmodule

// file: scu_uart_tb_top.sv
`timescale 1ns/1ps
// ----------
// Bench top
// ----------
module scu_uart_tb_top;
    logic        clk_i = 1'b0, srst_i = 1'b1, rxd_i, clear_to_send_n_i, ev;
    logic [1:0]  serial_mode_select_i = 2'h1;
    logic [15:0] baud_period_integer_i = 16'h0008;
    logic        baud_period_half_step_i = 1'b0, eight_data_bits_i = 1'b1;
    logic        two_stop_bits_i = 1'b0, parity_enable_i = 1'b1, odd_parity_select_i = 1'b0;
    logic        flow_control_enable_i = 1'b0, auto_rts_enable_i = 1'b0;
    logic        rts_manual_level_i = 1'b0, tx_wr_i = 1'b0, rx_rd_i = 1'b0;
    logic        rx_dma_i = 1'b0, rx_dma_buf_b_i = 1'b0;
    logic [7:0]  tx_data_i = 8'h00, rx_dma_offset_i = 8'h00;
    logic [1:0]  dma_channel_reset_i = 2'h0, rx_dma_reload_i = 2'h0;
    logic [1:0]  tx_dma_buffer_active_i = 2'h0, rx_dma_buffer_active_i = 2'h0;
    logic        txd_o, request_to_send_n_o, tx_all_sent_o, tx_fifo_has_space_o;
    logic        rx_fifo_has_data_o, rx_parity_error_o, rx_framing_error_o;
    logic        rx_overrun_flag_o, uart_event_o, rx_overrun_irq_o;
    logic [7:0]  serial_data_port_o, rx_dma_error_offset_a_o, rx_dma_error_offset_b_o;
    logic [7:0]  bv [5] = '{8'h01, 8'h80, 8'h55, 8'haa, 8'hc3};
    int          n_fail = 0, num_checks = 0, cyc = 0;

    scu_uart scu_uart_i (.*);
    scu_term #(.BIT(16)) scu_term_i (.clk_i, .txd_i(txd_o), .rxd_o(rxd_i),
                                     .cts_n_o(clear_to_send_n_i));

    // 40 ns clock and a hang limit well above the run length
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Five back-to-back writes: fifo full, then drained in order
    task t_tx;
        for (int i = 0; i < 5; i++) begin
            tx_data_i = bv[i];
            tx_wr_i = 1'b1;
            tick;
        end
        tx_wr_i = 1'b0;
        chk(tx_all_sent_o, 0);
        chk(tx_fifo_has_space_o, 0);
        for (int k = 0; k < 1500 && tx_all_sent_o !== 1'b1; k++) tick;
        chk(tx_all_sent_o, 1);
        chk(tx_fifo_has_space_o, 1);
        chk(scu_term_i.got_q.size() >= 4, 1);
        for (int i = 0; i < 4 && scu_term_i.got_q.size() > 0; i++)
            chk(scu_term_i.got_q.pop_front(), {^bv[i], bv[i]});
        $display("test tx done");
    endtask
    // Seven bits, no parity, two stops: line stays high after bit six
    task t_fmt;
        int k;
        eight_data_bits_i = 1'b0;
        parity_enable_i = 1'b0;
        two_stop_bits_i = 1'b1;
        tx_data_i = 8'h35;
        tx_wr_i = 1'b1;
        tick;
        tx_wr_i = 1'b0;
        for (k = 0; k < 400 && tx_all_sent_o !== 1'b1; k++) tick;
        chk(k >= 158 && k <= 170, 1);
        chk(scu_term_i.got_q.pop_front(), 9'h1b5);
        eight_data_bits_i = 1'b1;
        parity_enable_i = 1'b1;
        two_stop_bits_i = 1'b0;
        $display("test fmt done");
    endtask
    // Overrun with buffer A active: offset shows only once drained
    task t_ovf;
        rx_dma_buffer_active_i = 2'h1;
        rx_dma_offset_i = 8'h09;
        for (int i = 0; i < 5; i++) scu_term_i.send(bv[i], 1'b1, 1'b0, 1'b0);
        tick;
        chk(rx_overrun_flag_o, 1);
        chk(rx_dma_error_offset_a_o, 8'hff);
        rx_dma_i = 1'b1;
        repeat (4) tick;
        rx_dma_i = 1'b0;
        repeat (2) tick;
        chk(rx_dma_error_offset_a_o, 8'h09);
        rx_dma_reload_i = 2'h1;
        tick;
        rx_dma_reload_i = 2'h0;
        rx_dma_buffer_active_i = 2'h0;
        tick;
        chk(rx_dma_error_offset_a_o, 8'hff);
        $display("test ovf done");
    endtask
    // Auto flow level at each fill, overrun on the fifth byte
    task t_rx;
        flow_control_enable_i = 1'b1;
        auto_rts_enable_i = 1'b1;
        odd_parity_select_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            scu_term_i.send(bv[i], 1'b1, 1'b0, 1'b0);
            tick;
            chk(request_to_send_n_o, i >= 2);
        end
        chk(rx_overrun_flag_o, 1);
        rx_rd_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            chk(serial_data_port_o, bv[i]);
            tick;
        end
        rx_rd_i = 1'b0;
        chk(rx_fifo_has_data_o, 0);
        $display("test rx done");
    endtask
    // Manual flow level, then buffer-complete events
    task t_rts;
        auto_rts_enable_i = 1'b0;
        for (int v = 0; v < 2; v++) begin
            rts_manual_level_i = v[0];
            tick;
            tick;
            chk(request_to_send_n_o, !v[0]);
        end
        for (int k = 0; k < 4; k++) begin
            tx_dma_buffer_active_i = 2'h3;
            rx_dma_buffer_active_i = 2'h3;
            repeat (3) tick;
            if (k < 2) tx_dma_buffer_active_i[k] = 1'b0;
            else rx_dma_buffer_active_i[k-2] = 1'b0;
            ev = 1'b0;
            repeat (3) begin
                tick;
                ev |= uart_event_o;
            end
            chk(ev, 1);
        end
        $display("test rts done");
    endtask
    // Bad parity through DMA offset, clear, then a bad stop bit
    task t_err;
        rx_dma_reload_i = 2'h3;
        tick;
        rx_dma_reload_i = 2'h0;
        scu_term_i.send(8'h5a, 1'b1, 1'b1, 1'b0);
        tick;
        chk(rx_parity_error_o, 1);
        chk(rx_framing_error_o, 0);
        rx_dma_offset_i = 8'h05;
        rx_dma_i = 1'b1;
        tick;
        rx_dma_i = 1'b0;
        tick;
        chk(rx_dma_error_offset_a_o, 8'h05);
        chk(rx_dma_error_offset_b_o, 8'hff);
        dma_channel_reset_i = 2'h1;
        tick;
        dma_channel_reset_i = 2'h0;
        tick;
        chk(rx_dma_error_offset_a_o, 8'hff);
        scu_term_i.send(8'h11, 1'b1, 1'b0, 1'b1);
        tick;
        chk(rx_framing_error_o, 1);
        // Long read flushes any frame seen in the low stop bit
        rx_rd_i = 1'b1;
        repeat (300) tick;
        rx_rd_i = 1'b0;
        $display("test err done");
    endtask
    // No reception outside UART mode
    task t_mode;
        for (int m = 0; m < 4; m++) begin
            if (m == 1) continue;
            serial_mode_select_i = m[1:0];
            scu_term_i.send(8'h77, 1'b1, 1'b0, 1'b0);
            repeat (4) tick;
            chk(rx_fifo_has_data_o, 0);
        end
        serial_mode_select_i = 2'h1;
        $display("test mode done");
    endtask

    initial begin
        repeat (5) tick;
        srst_i = 1'b0;
        tick;
        chk({uart_event_o, txd_o, request_to_send_n_o, tx_all_sent_o, tx_fifo_has_space_o},
            9'h00f);
        chk(rx_dma_error_offset_a_o & rx_dma_error_offset_b_o, 8'hff);
        t_tx;
        t_fmt;
        t_rx;
        t_rts;
        t_err;
        t_ovf;
        t_mode;
        results();
    end
endmodule

bind scu_uart scu_uart_sva scu_uart_sva_i (.*);
